/* rtl/kmsl_defines.vh */
// constants of the keyboard and mouse serial link device end
`ifndef KMSL_DEFINES_VH
`define KMSL_DEFINES_VH

// ----------------------------------------------------------------
// system clock and link timing
// ----------------------------------------------------------------
`define KMSL_CLK_NS       40
// clock phase length, inside the 30..50 us window
`define KMSL_HALF_NS      40000
`define KMSL_HALF_CYC     ((`KMSL_HALF_NS + `KMSL_CLK_NS - 1) / `KMSL_CLK_NS)
// data change ahead of the falling clock edge, 5..25 us
`define KMSL_SETUP_NS     15000
`define KMSL_SETUP_CYC    ((`KMSL_SETUP_NS + `KMSL_CLK_NS - 1) / `KMSL_CLK_NS)
// rising clock edge to next data change
`define KMSL_HOLD_NS      25000
`define KMSL_HOLD_CYC     ((`KMSL_HOLD_NS + `KMSL_CLK_NS - 1) / `KMSL_CLK_NS)
// host halt poll interval, a longest time
`define KMSL_POLL_NS      100000
`define KMSL_POLL_CYC     (`KMSL_POLL_NS / `KMSL_CLK_NS)
// inter-byte gap, a least time
`define KMSL_GAP_NS       1000000
`define KMSL_GAP_CYC      ((`KMSL_GAP_NS + `KMSL_CLK_NS - 1) / `KMSL_CLK_NS)
// typematic delay and repeat period
`define KMSL_DELAY_MS     500
`define KMSL_DELAY_CYC    (`KMSL_DELAY_MS * 1000000 / `KMSL_CLK_NS)
`define KMSL_RATE_MS      100
`define KMSL_RATE_CYC     (`KMSL_RATE_MS * 1000000 / `KMSL_CLK_NS)
`define KMSL_SETTLE_CYC   4'hF

// ----------------------------------------------------------------
// frame and code values
// ----------------------------------------------------------------
`define KMSL_FRAME_BITS   11
`define KMSL_PARITY_IDX   4'h9
`define KMSL_STOP_IDX     4'hA
`define KMSL_FIFO_DEPTH   24
`define KMSL_CODE_BREAK   8'hF0
`define KMSL_CODE_EXT     8'hE0
`define KMSL_CODE_ACK     8'hFA
`define KMSL_CODE_RESEND  8'hFE
`define KMSL_CODE_BAT     8'hAA
`define KMSL_CODE_ID      8'h00
`define KMSL_CODE_OVERRUN 8'h00
`define KMSL_CODE_CTRL    8'h14

`endif

/* rtl/kmsl_sync.v */
// three-stage synchroniser for one line level from outside the domain
`timescale 1ns/10ps
`default_nettype none

module kmsl_sync (
  input  wire clock_in,
  input  wire rstn_in,
  input  wire async_in,
  output reg  level_out
);

  reg stage1;
  reg stage2;
  reg stage3;

  // lines rest high, so reset to the idle level
  always @(posedge clock_in) begin
    if (!rstn_in) begin
      stage1    <= 1'b1;
      stage2    <= 1'b1;
      stage3    <= 1'b1;
      level_out <= 1'b1;
    end else begin
      stage1 <= async_in;
      stage2 <= stage1;
      stage3 <= stage2;
      if (stage2 == stage3) begin
        level_out <= stage3;
      end
    end
  end

endmodule // kmsl_sync

`default_nettype wire

/* rtl/kmsl_link.v */
// device end of the keyboard and mouse two-wire serial link
`timescale 1ns/10ps
`default_nettype none
`include "kmsl_defines.vh"

module kmsl_link #(
  parameter        DEPTH     = `KMSL_FIFO_DEPTH,
  parameter [23:0] GAP_CYC   = `KMSL_GAP_CYC,
  parameter [23:0] DELAY_CYC = `KMSL_DELAY_CYC,
  parameter [23:0] RATE_CYC  = `KMSL_RATE_CYC
) (
  input  wire        clock_in,
  input  wire        rstn_in,
  input  wire        link_clock_line_in,
  output reg         link_clock_line_out,
  output reg         link_clock_line_oe_out,
  input  wire        link_data_line_in,
  output reg         link_data_line_out,
  output reg         link_data_line_oe_out,
  input  wire        key_valid_in,
  input  wire [7:0]  key_code_in,
  input  wire        key_ext_in,
  input  wire        key_release_in,
  input  wire        function_modifier_key_in,
  output reg         key_ready_out,
  input  wire        mouse_valid_in,
  input  wire [23:0] mouse_packet_in,
  output reg         mouse_ready_out,
  output reg  [7:0]  sys_code_out,
  output reg         sys_code_valid_out,
  output reg         sys_code_mapped_out,
  output reg  [7:0]  rx_data_out,
  output reg         rx_valid_out,
  output reg         rx_parity_err_out
);

  // ----------------------------------------------------------------
  // states and constants
  // ----------------------------------------------------------------
  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_TSET  = 3'h1;
  localparam [2:0] ST_TLOW  = 3'h2;
  localparam [2:0] ST_THIGH = 3'h3;
  localparam [2:0] ST_RLOW  = 3'h4;
  localparam [2:0] ST_RHIGH = 3'h5;
  localparam integer HALF_I   = `KMSL_HALF_CYC;
  localparam integer SETUP_I  = `KMSL_SETUP_CYC;
  localparam integer HOLD_I   = `KMSL_HOLD_CYC;
  localparam integer DEPTH_I  = DEPTH - 1;
  localparam [15:0] HALF_CYC  = HALF_I[15:0];
  localparam [15:0] SETUP_CYC = SETUP_I[15:0];
  localparam [15:0] HOLD_CYC  = HOLD_I[15:0];
  localparam [5:0]  DEPTH_M1  = DEPTH_I[5:0];

  // ----------------------------------------------------------------
  // code helpers
  // ----------------------------------------------------------------
  // length in [25:24], bytes first-out in [23:16]
  // break and extended prefixes
  function [25:0] key_seq;
    input [7:0] code;
    input       ext;
    input       rel;
    begin
      if (ext && rel) begin
        key_seq = {2'h3, `KMSL_CODE_EXT, `KMSL_CODE_BREAK, code};
      end else if (ext) begin
        key_seq = {2'h2, `KMSL_CODE_EXT, code, 8'h00};
      end else if (rel) begin
        key_seq = {2'h2, `KMSL_CODE_BREAK, code, 8'h00};
      end else begin
        key_seq = {2'h1, code, 16'h0000};
      end
    end
  endfunction

  // mapped flag in [8]; unlisted codes pass through unchanged with the flag clear
  // non-standard code table
  function [8:0] to_system;
    input [7:0] code;
    begin
      case (code)
        8'h6A:   to_system = {1'b1, 8'h7D};
        8'h5D:   to_system = {1'b1, 8'h2B};
        8'h61:   to_system = {1'b1, 8'h56};
        8'h10:   to_system = {1'b1, 8'h65};
        8'h20:   to_system = {1'b1, 8'h67};
        8'h30:   to_system = {1'b1, 8'h69};
        8'h40:   to_system = {1'b1, 8'h6B};
        default: to_system = {1'b0, code};
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // line synchronisers
  // ----------------------------------------------------------------
  wire clk_s;
  wire dat_s;

  kmsl_sync u_clk_sync (
    .clock_in  (clock_in),
    .rstn_in   (rstn_in),
    .async_in  (link_clock_line_in),
    .level_out (clk_s)
  );

  kmsl_sync u_dat_sync (
    .clock_in  (clock_in),
    .rstn_in   (rstn_in),
    .async_in  (link_data_line_in),
    .level_out (dat_s)
  );

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  reg  [7:0]  fifo_mem [0:DEPTH-1];
  reg  [4:0]  wr_ptr;
  reg  [4:0]  rd_ptr;
  reg  [5:0]  fifo_cnt;
  reg  [23:0] em_seq;
  reg  [1:0]  em_len;
  reg         ovr_pend;
  reg         ovr_done;
  reg         boot_pend;
  reg         ack_pend;
  reg  [7:0]  ack_code;
  reg  [7:0]  rep_code;
  reg         rep_ext;
  reg         rep_active;
  reg  [23:0] rep_cnt;
  reg  [2:0]  state;
  reg  [15:0] ph_cnt;
  reg  [23:0] gap_cnt;
  reg         gap_arm;
  reg  [3:0]  bit_idx;
  reg  [3:0]  rel_cnt;
  reg  [10:0] tx_sh;
  reg  [8:0]  rx_sh;
  reg         push_en;
  reg  [7:0]  push_byte;
  reg  [23:0] ld_seq;
  reg  [1:0]  ld_len;
  reg         ld_rep;
  reg         ld_key;

  wire        em_idle  = (em_len == 2'h0) && !ovr_pend;
  wire        offering = key_ready_out || mouse_ready_out;
  wire        rep_due  = rep_active && (rep_cnt == 24'h0);
  wire        ext_eff  = key_ext_in || (function_modifier_key_in &&
                         (key_code_in == `KMSL_CODE_CTRL));
  wire [25:0] kseq     = key_seq(key_code_in, ext_eff, key_release_in);
  wire [25:0] rseq     = key_seq(rep_code, rep_ext, 1'b0);
  wire [8:0]  sys      = to_system(key_code_in);
  wire        ld_fit   = (fifo_cnt + {4'h0, ld_len}) <= DEPTH_M1;
  wire        settled  = (rel_cnt == `KMSL_SETTLE_CYC);
  wire        tx_phase = (state == ST_TSET) || (state == ST_THIGH);
  wire        pop      = (state == ST_THIGH) && (ph_cnt == 16'h0) &&
                         (bit_idx == `KMSL_STOP_IDX);

  // ----------------------------------------------------------------
  // code source selection
  // ----------------------------------------------------------------
  always @* begin
    ld_seq = 24'h000000;
    ld_len = 2'h0;
    ld_rep = 1'b0;
    ld_key = 1'b0;
    if (key_ready_out && key_valid_in) begin
      ld_seq = kseq[23:0];
      ld_len = kseq[25:24];
      ld_key = 1'b1;
    end else if (mouse_ready_out && mouse_valid_in) begin
      ld_seq = mouse_packet_in;
      ld_len = 2'h3;
    end else if (em_idle && !offering && boot_pend) begin
      ld_seq = {`KMSL_CODE_BAT, `KMSL_CODE_ID, 8'h00};
      ld_len = 2'h2;
    end else if (em_idle && !offering && ack_pend) begin
      ld_seq = {ack_code, 16'h0000};
      ld_len = 2'h1;
    end else if (em_idle && !offering && !key_valid_in && rep_due) begin
      ld_seq = rseq[23:0];
      ld_len = rseq[25:24];
      ld_rep = 1'b1;
    end
  end

  // one byte per cycle into the buffer; overrun when the whole sequence does not fit with one slot spare
  always @* begin
    push_en   = 1'b0;
    push_byte = em_seq[23:16];
    if (em_len != 2'h0) begin
      push_en = 1'b1;
    end else if (ovr_pend) begin
      push_en   = 1'b1;
      push_byte = `KMSL_CODE_OVERRUN;
    end
  end

  // ----------------------------------------------------------------
  // character buffer
  // ----------------------------------------------------------------
  always @(posedge clock_in) begin
    if (push_en) begin
      fifo_mem[wr_ptr] <= push_byte;
    end
  end

  always @(posedge clock_in) begin
    if (!rstn_in) begin
      wr_ptr   <= 5'h00;
      rd_ptr   <= 5'h00;
      fifo_cnt <= 6'h00;
    end else begin
      if (push_en) begin
        wr_ptr <= (wr_ptr == DEPTH_M1[4:0]) ? 5'h00 : wr_ptr + 5'h01;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == DEPTH_M1[4:0]) ? 5'h00 : rd_ptr + 5'h01;
      end
      fifo_cnt <= fifo_cnt + {5'h00, push_en} - {5'h00, pop};
    end
  end

  // ----------------------------------------------------------------
  // code generation, typematic and translation
  // ----------------------------------------------------------------
  always @(posedge clock_in) begin
    if (!rstn_in) begin
      em_seq              <= 24'h000000;
      em_len              <= 2'h0;
      ovr_pend            <= 1'b0;
      ovr_done            <= 1'b0;
      boot_pend           <= 1'b1;
      ack_pend            <= 1'b0;
      rep_code            <= 8'h00;
      rep_ext             <= 1'b0;
      rep_active          <= 1'b0;
      rep_cnt             <= 24'h000000;
      key_ready_out       <= 1'b0;
      mouse_ready_out     <= 1'b0;
      sys_code_out        <= 8'h00;
      sys_code_valid_out  <= 1'b0;
      sys_code_mapped_out <= 1'b0;
    end else begin
      sys_code_valid_out <= 1'b0;
      key_ready_out      <= 1'b0;
      mouse_ready_out    <= 1'b0;
      if (em_len != 2'h0) begin
        em_seq <= {em_seq[15:0], 8'h00};
        em_len <= em_len - 2'h1;
      end
      if (ovr_pend) begin
        ovr_pend <= 1'b0;
      end
      if (fifo_cnt == 6'h00) begin
        ovr_done <= 1'b0;
      end
      if (rep_cnt != 24'h0) begin
        rep_cnt <= rep_cnt - 24'h1;
      end
      // one source offered per free slot, key first
      if (em_idle && !offering && !boot_pend && !ack_pend) begin
        if (key_valid_in) begin
          key_ready_out <= 1'b1;
        end else if (!rep_due && mouse_valid_in) begin
          mouse_ready_out <= 1'b1;
        end
      end
      if (ld_len != 2'h0) begin
        if (ld_fit) begin
          em_seq <= ld_seq;
          em_len <= ld_len;
        end else if (!ovr_done) begin
          ovr_pend <= 1'b1;
          ovr_done <= 1'b1;
        end
        if (!(key_ready_out && key_valid_in) &&
            !(mouse_ready_out && mouse_valid_in)) begin
          if (boot_pend) begin
            boot_pend <= 1'b0;
          end else if (ack_pend) begin
            ack_pend <= 1'b0;
          end
        end
      end
      if (ld_rep) begin
        rep_cnt <= RATE_CYC;
      end
      if (ld_key) begin
        sys_code_out        <= sys[7:0];
        sys_code_mapped_out <= sys[8];
        sys_code_valid_out  <= 1'b1;
        if (!key_release_in) begin
          rep_code   <= key_code_in;
          rep_ext    <= ext_eff;
          rep_active <= 1'b1;
          rep_cnt    <= DELAY_CYC;
        end else if (key_code_in == rep_code) begin
          rep_active <= 1'b0;
        end
      end
      if (state == ST_RHIGH && ph_cnt == 16'h0 &&
          bit_idx == `KMSL_STOP_IDX) begin
        ack_pend <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // link sequencer
  // ----------------------------------------------------------------
  always @(posedge clock_in) begin
    if (!rstn_in) begin
      state                  <= ST_IDLE;
      ph_cnt                 <= 16'h0000;
      gap_cnt                <= 24'h000000;
      gap_arm                <= 1'b0;
      bit_idx                <= 4'h0;
      rel_cnt                <= 4'h0;
      tx_sh                  <= 11'h7FF;
      rx_sh                  <= 9'h000;
      ack_code               <= `KMSL_CODE_ACK;
      link_clock_line_out    <= 1'b0;
      link_clock_line_oe_out <= 1'b0;
      link_data_line_out     <= 1'b0;
      link_data_line_oe_out  <= 1'b0;
      rx_data_out            <= 8'h00;
      rx_valid_out           <= 1'b0;
      rx_parity_err_out      <= 1'b0;
    end else begin
      rx_valid_out <= 1'b0;
      // sync lag hides our own release, so wait before trusting
      if (link_clock_line_oe_out) begin
        rel_cnt <= 4'h0;
      end else if (!settled) begin
        rel_cnt <= rel_cnt + 4'h1;
      end
      if (gap_cnt != 24'h0) begin
        gap_cnt <= gap_cnt - 24'h1;
      end
      if (ph_cnt != 16'h0) begin
        ph_cnt <= ph_cnt - 16'h1;
      end
      case (state)
        ST_IDLE: begin
          link_clock_line_oe_out <= 1'b0;
          link_data_line_oe_out  <= 1'b0;
          if (settled && clk_s && !dat_s) begin
            state                  <= ST_RLOW;
            bit_idx                <= 4'h0;
            ph_cnt                 <= HALF_CYC;
            link_clock_line_oe_out <= 1'b1;
          end else if (gap_arm && gap_cnt == 24'h0 && !clk_s) begin
            gap_cnt <= GAP_CYC;
          end else if (settled && clk_s && dat_s && gap_cnt == 24'h0 &&
                       fifo_cnt != 6'h00) begin
            tx_sh <= {1'b1, ~^fifo_mem[rd_ptr], fifo_mem[rd_ptr], 1'b0};
            link_data_line_oe_out <= 1'b1;
            gap_arm <= 1'b0;
            bit_idx <= 4'h0;
            ph_cnt  <= SETUP_CYC;
            state   <= ST_TSET;
          end
        end
        ST_TSET, ST_TLOW, ST_THIGH: begin
          // clock watched in every released phase up to the parity-bit setup
          // looks are at most one low phase apart, well under 100 us
          if (tx_phase && settled && !clk_s &&
              (bit_idx < `KMSL_PARITY_IDX ||
               (bit_idx == `KMSL_PARITY_IDX && state == ST_TSET))) begin
            // abort; byte stays at buffer head
            link_data_line_oe_out <= 1'b0;
            state                 <= ST_IDLE;
          end else if (ph_cnt == 16'h0) begin
            if (state == ST_TSET) begin
              link_clock_line_oe_out <= 1'b1;
              ph_cnt <= HALF_CYC;
              state  <= ST_TLOW;
              if (bit_idx == `KMSL_STOP_IDX) begin
                // gap from stop-bit data change; short gaps clamp at zero
                if (GAP_CYC > {8'h00, SETUP_CYC}) begin
                  gap_cnt <= GAP_CYC - {8'h00, SETUP_CYC};
                end else begin
                  gap_cnt <= 24'h000000;
                end
                gap_arm <= 1'b1;
              end
            end else if (state == ST_TLOW) begin
              link_clock_line_oe_out <= 1'b0;
              ph_cnt <= HOLD_CYC;
              state  <= ST_THIGH;
            end else if (bit_idx == `KMSL_STOP_IDX) begin
              link_data_line_oe_out <= 1'b0;
              state <= ST_IDLE;
            end else begin
              tx_sh   <= {1'b1, tx_sh[10:1]};
              link_data_line_oe_out <= ~tx_sh[1];
              bit_idx <= bit_idx + 4'h1;
              ph_cnt  <= SETUP_CYC;
              state   <= ST_TSET;
            end
          end
        end
        ST_RLOW: begin
          if (ph_cnt == 16'h0) begin
            if (bit_idx != 4'h0 && bit_idx != `KMSL_STOP_IDX) begin
              rx_sh <= {dat_s, rx_sh[8:1]};
            end
            if (bit_idx == `KMSL_STOP_IDX) begin
              link_data_line_oe_out <= 1'b0;
            end
            link_clock_line_oe_out <= 1'b0;
            ph_cnt <= HALF_CYC;
            state  <= ST_RHIGH;
          end
        end
        ST_RHIGH: begin
          if (bit_idx == `KMSL_PARITY_IDX && ph_cnt == SETUP_CYC) begin
            link_data_line_oe_out <= 1'b1;
          end
          if (ph_cnt == 16'h0) begin
            if (bit_idx == `KMSL_STOP_IDX) begin
              rx_data_out       <= rx_sh[7:0];
              rx_parity_err_out <= ~^rx_sh;
              rx_valid_out      <= 1'b1;
              ack_code <= (~^rx_sh) ? `KMSL_CODE_RESEND : `KMSL_CODE_ACK;
              state    <= ST_IDLE;
            end else begin
              bit_idx <= bit_idx + 4'h1;
              link_clock_line_oe_out <= 1'b1;
              ph_cnt <= HALF_CYC;
              state  <= ST_RLOW;
            end
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // kmsl_link

`default_nettype wire

/* verif/kmsl_link_properties.sv */
// assertion checker of the serial link device end
`timescale 1ns/10ps
`default_nettype none
module kmsl_link_checker (
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire logic link_clock_line_in,
  input wire logic link_clock_line_out,
  input wire logic link_clock_line_oe_out,
  input wire logic link_data_line_in,
  input wire logic link_data_line_out,
  input wire logic link_data_line_oe_out,
  input wire logic key_valid_in,
  input wire logic key_ready_out,
  input wire logic sys_code_valid_out
);
  // ----------------------------------------
  // phase counters; hi_cnt and dst_cnt saturate while idle, lo_cnt and hl_cnt clear
  // ----------------------------------------
  wire logic   c_oe = link_clock_line_oe_out;
  wire logic   d_oe = link_data_line_oe_out;
  logic [15:0] lo_cnt, hi_cnt, dst_cnt, hl_cnt;
  always @(posedge clock_in) begin
    if (!rstn_in) begin
      lo_cnt  <= 16'h0000;
      hi_cnt  <= 16'hFFFF;
      dst_cnt <= 16'hFFFF;
      hl_cnt  <= 16'h0000;
    end else begin
      lo_cnt  <= c_oe ? lo_cnt + 16'h0001 : 16'h0000;
      hi_cnt  <= c_oe ? 16'h0000 : hi_cnt + {15'h0000, ~&hi_cnt};
      dst_cnt <= $changed(d_oe) ? 16'h0000 : dst_cnt + {15'h0000, ~&dst_cnt};
      // host alone holds the clock wire low
      hl_cnt  <= link_clock_line_in | c_oe ? 16'h0000 : hl_cnt + 16'h0001;
    end
  end
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rstn_in);
  property p_open; !link_clock_line_out && !link_data_line_out; endproperty
  property p_low; $fell(c_oe) |-> lo_cnt > 16'h02ED && lo_cnt < 16'h04E3;
  endproperty
  property p_setup; $rose(c_oe) |-> dst_cnt >= 16'h007D; endproperty
  property p_still; c_oe && $past(c_oe) |-> $stable(d_oe); endproperty
  property p_idle;
    $rose(d_oe) && hi_cnt > 16'h0514 |->
      $past(link_clock_line_in, 4) && $past(link_data_line_in, 4);
  endproperty
  property p_start; $rose(c_oe) && hi_cnt > 16'h0514 |-> !link_data_line_in;
  endproperty
  property p_halt; hl_cnt == 16'h04B0 |-> !d_oe; endproperty
  property p_take; key_ready_out && key_valid_in |=> sys_code_valid_out;
  endproperty
  a_open: assert property (p_open) else $error("line driven high");
  a_low: assert property (p_low) else $error("clock low phase");
  a_setup: assert property (p_setup) else $error("data setup");
  a_still: assert property (p_still) else $error("data moved");
  a_idle: assert property (p_idle) else $error("start not idle");
  a_start: assert property (p_start) else $error("start bit high");
  a_halt: assert property (p_halt) else $error("halt ignored");
  a_take: assert property (p_take) else $error("no code valid");
  c_halt: cover property (hl_cnt == 16'h04B0);
  c_take: cover property (key_ready_out && key_valid_in);
  c_start: cover property ($rose(c_oe) && hi_cnt > 16'h0514);
endmodule // kmsl_link_checker
bind kmsl_link kmsl_link_checker i_kmsl_link_checker (
  .clock_in, .rstn_in, .link_clock_line_in, .link_clock_line_out,
  .link_clock_line_oe_out, .link_data_line_in, .link_data_line_out,
  .link_data_line_oe_out, .key_valid_in, .key_ready_out, .sys_code_valid_out
);
`default_nettype wire

/* verif/kmsl_host_model.sv */
// host-side model of the serial link partner
`timescale 1ns/10ps
`default_nettype none
module kmsl_host_model (
  input  wire logic       clock_in,
  input  wire logic       clk_wire_in,
  input  wire logic       data_wire_in,
  input  wire logic       halt_in,
  input  wire logic       send_in,
  input  wire logic [7:0] send_byte_in,
  output var  logic       clk_oe_out,
  output var  logic       data_oe_out,
  output var  logic [7:0] byte_out,
  output var  logic       byte_ok_out,
  output var  logic       strobe_out
);
  // ----------------------------------------
  // wire watcher and host frame sender
  // ----------------------------------------
  logic        prev = 1'b1;
  logic [3:0]  nbit = 4'h0;
  logic [3:0]  tx_n = 4'h0;
  logic [10:0] sh = 11'h000;
  int          hold = 0;
  initial {clk_oe_out, data_oe_out, strobe_out} = 3'h0;
  always @(posedge clock_in) begin
    prev <= clk_wire_in;
    strobe_out <= 1'b0;
    if (hold > 0) begin
      hold <= hold - 1;
      clk_oe_out <= hold > 1;
    end else if (halt_in) begin
      hold <= 2600;
      clk_oe_out <= 1'b1;
      nbit <= 4'h0;
    end else if (send_in) begin
      data_oe_out <= 1'b1;
      tx_n <= 4'h1;
    end else if (tx_n != 4'h0 && !prev && clk_wire_in) begin
      // lsb first, odd parity, stop left to device
      data_oe_out <= tx_n < 4'h9 ? !send_byte_in[tx_n - 4'h1]
                                 : tx_n == 4'h9 && ^send_byte_in;
      tx_n <= tx_n == 4'hB ? 4'h0 : tx_n + 4'h1;
    end else if (tx_n == 4'h0 && prev && !clk_wire_in) begin
      sh <= {data_wire_in, sh[10:1]};
      nbit <= nbit == 4'hA ? 4'h0 : nbit + 4'h1;
      if (nbit == 4'hA) begin
        // frame shape and odd parity, last bit still on the wire
        byte_out <= sh[9:2];
        byte_ok_out <= !sh[1] && data_wire_in && ^sh[10:2];
        strobe_out <= 1'b1;
        hold <= 1200;
        clk_oe_out <= 1'b1;
      end
    end
  end
endmodule // kmsl_host_model
`default_nettype wire

/* verif/kmsl_link_tb.sv */
// self-checking bench of the serial link device end
`timescale 1ns/10ps
`default_nettype none
module kmsl_link_tb;
  logic        clock_in, rstn_in, c_oe, d_oe, h_c_oe, h_d_oe, halt, send;
  logic        hstb, hok, k_valid, k_ready, s_valid, s_map, rx_valid, rx_perr;
  logic [7:0]  k_code, s_code, rx_data, hb, send_b;
  logic        k_ext, k_rel, k_fn;
  logic [31:0] r, seed = 32'h86EEA07B;
  int          miscompares = 0;
  int          cmp_count = 0;
  wire logic  c_w = !(c_oe | h_c_oe);
  wire logic  d_w = !(d_oe | h_d_oe);
  logic [7:0] keys [7] = '{8'h6A, 8'h5D, 8'h61, 8'h10, 8'h20, 8'h30, 8'h40};
  kmsl_link #(.GAP_CYC(24'h000032), .DELAY_CYC(24'h0000C8),
    .RATE_CYC(24'h000064)) i_kmsl_link (
    .clock_in(clock_in), .rstn_in(rstn_in), .link_clock_line_in(c_w),
    .link_clock_line_out(), .link_clock_line_oe_out(c_oe),
    .link_data_line_in(d_w), .link_data_line_out(),
    .link_data_line_oe_out(d_oe), .key_valid_in(k_valid),
    .key_code_in(k_code), .key_ext_in(k_ext), .key_release_in(k_rel),
    .function_modifier_key_in(k_fn), .key_ready_out(k_ready),
    .mouse_valid_in(1'b0), .mouse_packet_in(24'h000000),
    .mouse_ready_out(), .sys_code_out(s_code), .sys_code_valid_out(s_valid),
    .sys_code_mapped_out(s_map), .rx_data_out(rx_data),
    .rx_valid_out(rx_valid), .rx_parity_err_out(rx_perr));
  kmsl_host_model i_kmsl_host_model (.clock_in(clock_in), .clk_wire_in(c_w),
    .data_wire_in(d_w), .halt_in(halt), .send_in(send),
    .send_byte_in(send_b), .clk_oe_out(h_c_oe), .data_oe_out(h_d_oe),
    .byte_out(hb), .byte_ok_out(hok), .strobe_out(hstb));
  // ----------------------------------------
  // helpers and stimulus
  // ----------------------------------------
  initial begin
    clock_in = 1'b0;
    forever #20 clock_in = ~clock_in;
  end
  function automatic logic [31:0] xorshift();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [7:0] sys_of(input logic [7:0] c);
    case (c)
      8'h6A: return 8'h7D;
      8'h5D: return 8'h2B;
      8'h61: return 8'h56;
      8'h10: return 8'h65;
      8'h20: return 8'h67;
      8'h30: return 8'h69;
      8'h40: return 8'h6B;
      default: return c;
    endcase
  endfunction
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wait_flag(input int k);
    int n;
    n = 0;
    while ((k == 0 ? hstb : k == 1 ? rx_valid : k == 2 ? k_ready : d_oe)
           !== 1'b1 && n < 40000) begin
      @(negedge clock_in);
      n++;
    end
    if (n >= 40000) begin
      miscompares++;
      end_sim();
    end
  endtask
  task automatic expect_byte(input logic [7:0] exp);
    wait_flag(0);
    check("link byte", hb, exp);
    check("frame shape", {7'h00, hok}, 8'h01);
    @(negedge clock_in);
  endtask
  initial begin
    {rstn_in, k_valid, halt, send} = 4'h0;
    {k_ext, k_rel, k_fn} = 3'h0;
    {k_code, send_b} = 16'h0000;
    repeat (5) @(posedge clock_in);
    @(negedge clock_in);
    rstn_in = 1'b1;
    // halt the first frame early; it must come again whole
    wait_flag(3);
    repeat (500) @(negedge clock_in);
    halt = 1'b1;
    @(negedge clock_in);
    halt = 1'b0;
    expect_byte(8'hAA);
    expect_byte(8'h00);
    $display("boot and halt test done");
    repeat (1400) @(negedge clock_in);
    r = xorshift();
    send_b = r[7:0];
    send = 1'b1;
    @(negedge clock_in);
    send = 1'b0;
    wait_flag(1);
    check("host byte", rx_data, send_b);
    check("parity flag", {7'h00, rx_perr}, 8'h00);
    expect_byte(8'hFA);
    $display("host frame test done");
    for (int i = 0; i < 10; i++) begin
      r = xorshift();
      k_code = i < 7 ? keys[i] : {4'h0, r[3:0]} | 8'h01;
      // first key is a release, so its prefix leads the link
      k_rel = i == 0 ? 1'b1 : r[4];
      k_ext = i == 0 ? 1'b0 : r[5];
      k_fn = r[6];
      k_valid = 1'b1;
      wait_flag(2);
      @(negedge clock_in);
      k_valid = 1'b0;
      check("taken", {7'h00, s_valid}, 8'h01);
      check("system code", s_code, sys_of(k_code));
      check("mapped", {7'h00, s_map}, {7'h00, sys_of(k_code) != k_code});
      @(negedge clock_in);
    end
    expect_byte(8'hF0);
    $display("key code test done");
    end_sim();
  end
endmodule // kmsl_link_tb
`default_nettype wire
